// [verilog/exec_pkg.sv]
// Shared types and constants for the move, step, jump and power-down executor.
package exec_pkg;

  // ==========================================================================
  // Widths and fixed values
  localparam int DATA_W = 8;
  localparam int MEM_AW = 8;
  localparam int PC_W = 11;
  localparam logic [DATA_W-1:0] STEP_ONE = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [PC_W-1:0] PC_STEP = 11'h001;

  // ==========================================================================
  // Instruction encoding handed over by the fetch logic
  typedef enum logic [3:0] {
    op_nop,
    reduce_in_place,
    reduce_into_accumulator,
    raise_in_place,
    raise_into_accumulator,
    jump_unconditional,
    copy_operation_mem_to_acc,
    copy_operation_lit_to_acc,
    copy_operation_acc_to_mem,
    power_down
  } op_t;

  typedef struct packed {
    op_t op;
    logic [MEM_AW-1:0] operand_addr;
    logic [DATA_W-1:0] literal;
    logic [PC_W-1:0] target;
  } instr_t;

  // ==========================================================================
  // Status flags kept by this block
  typedef struct packed {
    logic zero_result;
    logic power_down_indicator;
    logic watchdog_expiry_flag;
  } status_t;

  localparam status_t STATUS_RESET = '{zero_result: 1'b0, power_down_indicator: 1'b0,
                                       watchdog_expiry_flag: 1'b0};

  // Memory write request as seen at the top ports.
  typedef struct packed {
    logic we;
    logic [MEM_AW-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_wr_t;

  localparam mem_wr_t MEM_WR_IDLE = '{we: 1'b0, addr: 8'h00, data: 8'h00};

endpackage

// [verilog/data_ram.sv]
// Single-port-write, registered-read data memory with write-to-read bypass.
module data_ram #(
  parameter int AW = 8,
  parameter int DW = 8,
  parameter int DEPTH = 256
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read side
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_r
);

  // Checked while elaborating, so a bad depth never reaches a run.
  if (DEPTH < 1 || DEPTH > (1 << AW))
  begin
    $error("data_ram: DEPTH does not fit the address width");
  end

  logic [DW-1:0] mem [DEPTH];

  // A write landing in the same cycle as a read of that byte must be seen,
  // otherwise back-to-back instructions on one location would read stale data.
  wire bypass = we && (waddr == raddr);

  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata_r <= bypass ? wdata : mem[raddr];
  end

endmodule

// [verilog/exec_core.sv]
// Executor for the step, copy, jump and power-down instruction group.
//
// Function
// - In-place decrement writes byte minus one, zero flag
// - Decrement into accumulator, memory kept, zero flag
// - Power-down stops execution, drops clk_run_r to request clock gating, keeps state
// - Power-down clears watchdog counter and prescaler
// - Power-down sets indicator, clears watchdog expiry flag unless a timeout comes in the same cycle
// - In-place increment writes byte plus one, zero flag
// - Increment into accumulator, memory kept, zero flag
// - Jump loads target into counter, flags untouched
// - Jump takes four cycles with two dummy slots
// - Memory to accumulator copy, flags untouched
// - Literal into accumulator, flags untouched
// - Accumulator to memory copy, flags untouched
module exec_core
  import exec_pkg::*;
#(
  parameter int MEM_DEPTH = 256
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Instruction fetch
  input wire instr_t instr,
  input wire logic instr_valid,
  output logic [PC_W-1:0] pc_r,
  output logic fetch_en_r,
  // Datapath state
  output logic [DATA_W-1:0] acc_r,
  output status_t status_r,
  output mem_wr_t mem_wr_r,
  output logic retire_r,
  // Watchdog and power control
  input wire logic watchdog_timeout,
  input wire logic wake,
  output logic watchdog_clear_r,
  output logic clk_run_r
);

  if (MEM_DEPTH < 1 || MEM_DEPTH > (1 << MEM_AW))
  begin
    $error("exec_core: MEM_DEPTH does not fit the operand address");
  end

  // ==========================================================================
  // Reset release and wake synchroniser
  logic rst_s1_r;
  logic rst_n_r;
  logic wake_s1_r;
  logic wake_s2_r;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end
    else
    begin
      wake_s1_r <= wake;
      wake_s2_r <= wake_s1_r;
    end
  end

  // ==========================================================================
  // Sequencer: an instruction cycle is a decode clock then an execute clock
  typedef enum logic [2:0] {
    st_decode,
    st_execute,
    st_dummy_a,
    st_dummy_b,
    st_halted
  } state_t;

  state_t state_r;
  state_t state_nxt;
  instr_t ir_r;
  logic [DATA_W-1:0] mem_rdata;

  // An offer counts only while the fetch enable is shown, so nothing is taken
  // in the first clock after reset, when the enable is still low.
  wire take_instr = (state_r == st_decode) && fetch_en_r && instr_valid;
  wire in_exec = (state_r == st_execute);
  wire op_jump = in_exec && (ir_r.op == jump_unconditional);
  wire op_halt = in_exec && (ir_r.op == power_down);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      st_decode:
        if (take_instr)
          state_nxt = st_execute;
      st_execute:
        if (ir_r.op == jump_unconditional)
          state_nxt = st_dummy_a;
        else if (ir_r.op == power_down)
          state_nxt = st_halted;
        else
          state_nxt = st_decode;
      st_dummy_a:
        state_nxt = st_dummy_b;
      st_dummy_b:
        state_nxt = st_decode;
      st_halted:
        if (wake_s2_r)
          state_nxt = st_decode;
      default:
        state_nxt = st_decode;
    endcase
  end

  // ==========================================================================
  // Datapath: results of the step operations wrap modulo 256
  wire [DATA_W-1:0] down_val = mem_rdata - STEP_ONE;
  wire [DATA_W-1:0] inc_val = mem_rdata + STEP_ONE;

  logic [DATA_W-1:0] acc_nxt;
  logic zero_upd;
  logic [DATA_W-1:0] zero_src;
  mem_wr_t mem_wr_nxt;

  always_comb
  begin
    acc_nxt = acc_r;
    zero_upd = 1'b0;
    zero_src = ZERO_BYTE;
    mem_wr_nxt = MEM_WR_IDLE;
    mem_wr_nxt.addr = ir_r.operand_addr;
    if (in_exec)
    begin
      case (ir_r.op)
        reduce_in_place:
        begin
          mem_wr_nxt.we = 1'b1;
          mem_wr_nxt.data = down_val;
          zero_upd = 1'b1;
          zero_src = down_val;
        end
        reduce_into_accumulator:
        begin
          acc_nxt = down_val;
          zero_upd = 1'b1;
          zero_src = down_val;
        end
        raise_in_place:
        begin
          mem_wr_nxt.we = 1'b1;
          mem_wr_nxt.data = inc_val;
          zero_upd = 1'b1;
          zero_src = inc_val;
        end
        raise_into_accumulator:
        begin
          acc_nxt = inc_val;
          zero_upd = 1'b1;
          zero_src = inc_val;
        end
        copy_operation_mem_to_acc:
          acc_nxt = mem_rdata;
        copy_operation_lit_to_acc:
          acc_nxt = ir_r.literal;
        copy_operation_acc_to_mem:
        begin
          mem_wr_nxt.we = 1'b1;
          mem_wr_nxt.data = acc_r;
        end
        default:
          acc_nxt = acc_r;
      endcase
    end
  end

  // ==========================================================================
  // Flags: a watchdog expiry in the same cycle as power-down is not lost
  status_t status_nxt;

  always_comb
  begin
    status_nxt = status_r;
    if (zero_upd)
      status_nxt.zero_result = (zero_src == ZERO_BYTE);
    if (op_halt)
    begin
      status_nxt.power_down_indicator = 1'b1;
      status_nxt.watchdog_expiry_flag = 1'b0;
    end
    if (watchdog_timeout)
      status_nxt.watchdog_expiry_flag = 1'b1;
  end

  // ==========================================================================
  // Program counter: jump target replaces the counter, flags left alone
  logic [PC_W-1:0] pc_nxt;

  assign pc_nxt = op_jump ? ir_r.target : (in_exec ? pc_r + PC_STEP : pc_r);

  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= st_decode;
      ir_r <= '0;
      pc_r <= PC_RESET;
      acc_r <= ACC_RESET;
      status_r <= STATUS_RESET;
      mem_wr_r <= MEM_WR_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
      if (take_instr)
        ir_r <= instr;
      pc_r <= pc_nxt;
      acc_r <= acc_nxt;
      status_r <= status_nxt;
      mem_wr_r <= mem_wr_nxt;
    end
  end

  // The core cannot stop its own clock, so the gate request is an output that
  // the clock unit acts on; while it is low the wake synchroniser and the watchdog expiry flag still update.
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      fetch_en_r <= 1'b0;
      clk_run_r <= 1'b1;
      watchdog_clear_r <= 1'b0;
      retire_r <= 1'b0;
    end
    else
    begin
      fetch_en_r <= (state_nxt == st_decode);
      clk_run_r <= (state_nxt != st_halted);
      watchdog_clear_r <= op_halt;
      retire_r <= in_exec;
    end
  end

  // ==========================================================================
  // Data memory: contents survive power-down since it has no reset
  data_ram #(
    .AW(MEM_AW),
    .DW(DATA_W),
    .DEPTH(MEM_DEPTH)
  ) data_ram_inst (
    .clk(core_clk),
    .we(mem_wr_r.we),
    .waddr(mem_wr_r.addr),
    .wdata(mem_wr_r.data),
    .raddr(instr.operand_addr),
    .rdata_r(mem_rdata)
  );

endmodule

// [verif/exec_core_properties.sv]
// Concurrent checks on the executor ports.
module exec_core_properties
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Fetch
  input wire instr_t instr,
  input wire logic instr_valid,
  input wire logic [PC_W-1:0] pc_r,
  input wire logic fetch_en_r,
  // Datapath
  input wire logic [DATA_W-1:0] acc_r,
  input wire status_t status_r,
  input wire mem_wr_t mem_wr_r,
  input wire logic retire_r,
  // Power control
  input wire logic watchdog_timeout,
  input wire logic wake,
  input wire logic watchdog_clear_r,
  input wire logic clk_run_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire logic take = fetch_en_r && instr_valid;

  step_write_back_a: assert property (take && instr.op == reduce_in_place |=> ##1 mem_wr_r.we &&
    mem_wr_r.addr == $past(instr.operand_addr, 2)) else $error("in-place step not written back");
  acc_step_zero_a: assert property (take && instr.op inside {reduce_into_accumulator,
    raise_into_accumulator} |=> ##1 !mem_wr_r.we && status_r.zero_result == (acc_r == ZERO_BYTE))
    else $error("acc step wrong");
  halt_stops_clock_a: assert property (take && instr.op == power_down |=> ##1
    watchdog_clear_r && !clk_run_r && !fetch_en_r) else $error("halt did not stop");
  halted_state_kept_a: assert property (!clk_run_r |=> $stable(acc_r)) else $error("acc moved while halted");
  halt_flags_a: assert property (take && instr.op == power_down |=> ##1
    status_r.power_down_indicator && status_r.watchdog_expiry_flag == $past(watchdog_timeout))
    else $error("halt flags wrong");
  jump_target_a: assert property (take && instr.op == jump_unconditional |=> ##1
    pc_r == $past(instr.target, 2)) else $error("jump target wrong");
  jump_dummy_slot_a: assert property (take && instr.op == jump_unconditional |=> ##1
    !fetch_en_r [*2] ##1 fetch_en_r) else $error("jump slot wrong");
  copy_flags_kept_a: assert property (take && instr.op inside {
    copy_operation_mem_to_acc, copy_operation_lit_to_acc, copy_operation_acc_to_mem, jump_unconditional}
    |=> ##1 status_r == $past(status_r, 2)) else $error("copy changed flags");
  literal_load_a: assert property (take && instr.op == copy_operation_lit_to_acc |=> ##1
    acc_r == $past(instr.literal, 2)) else $error("literal not loaded");
  acc_store_a: assert property (take && instr.op == copy_operation_acc_to_mem |=> ##1
    mem_wr_r == {1'b1, $past(instr.operand_addr, 2), acc_r}) else $error("acc store wrong");
  single_cycle_a: assert property (take |=> ##1 retire_r) else $error("no retire");
endmodule

bind exec_core exec_core_properties exec_core_properties_inst (.core_clk, .rstn, .instr, .instr_valid, .pc_r,
  .fetch_en_r, .acc_r, .status_r, .mem_wr_r, .retire_r, .watchdog_timeout, .wake, .watchdog_clear_r, .clk_run_r);

// [verif/prog_feed.sv]
// Program memory stand-in that offers one instruction until the executor takes it.
module prog_feed
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bench side
  input wire logic go,
  input wire instr_t instr_in,
  // Executor side
  input wire logic fetch_en_r,
  output instr_t instr,
  output logic instr_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  instr_t hold_r;
  // Outside an offer the word is inverted, so a stale word is never taken as good.
  assign instr = instr_valid ? hold_r : instr_t'(~hold_r);
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      hold_r <= '0;
      instr_valid <= 1'b0;
    end
    else if (go)
    begin
      hold_r <= instr_in;
      instr_valid <= 1'b1;
    end
    else if (fetch_en_r)
      instr_valid <= 1'b0;
endmodule

// [verif/exec_core_test.sv]
// Self-checking bench for the executor.
module exec_core_test
  import exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic go = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic wake = 1'b0;
  instr_t nxt = '0;
  instr_t instr;
  logic instr_valid, fetch_en_r, retire_r, watchdog_clear_r, clk_run_r;
  logic [PC_W-1:0] pc_r;
  logic [DATA_W-1:0] acc_r;
  status_t status_r;
  mem_wr_t mem_wr_r;
  int error_cnt = 0;
  int comparisons = 0;

  exec_core exec_core_inst (.core_clk, .rstn, .instr, .instr_valid, .pc_r, .fetch_en_r, .acc_r, .status_r,
    .mem_wr_r, .retire_r, .watchdog_timeout, .wake, .watchdog_clear_r, .clk_run_r);
  prog_feed prog_feed_inst (.core_clk, .rstn, .go, .instr_in(nxt), .fetch_en_r, .instr, .instr_valid);

  initial
  begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input string n, input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Offers one instruction and returns once it has retired.
  task automatic run(input op_t op, input logic [7:0] a, input logic [7:0] l, input logic [10:0] t);
    int n;
    nxt = '{op: op, operand_addr: a, literal: l, target: t};
    go = 1'b1;
    @(posedge core_clk) #5;
    go = 1'b0;
    for (n = 0; n < 30 && retire_r !== 1'b1; n++)
      @(posedge core_clk) #5;
    chk("retire", 17'(retire_r), 17'h00001);
  endtask

  initial
  begin
    repeat (20) @(posedge core_clk);
    #5 rstn = 1'b1;
    run(copy_operation_lit_to_acc, 8'h00, 8'hFF, 11'h000);
    chk("acc", 17'(acc_r), 17'h000FF);
    chk("status", 17'(status_r), 17'h00000);
    run(copy_operation_acc_to_mem, 8'h10, 8'h00, 11'h000);
    chk("mem_wr", mem_wr_r, 17'h110FF);
    run(raise_in_place, 8'h10, 8'h00, 11'h000);
    chk("mem_wr", mem_wr_r, 17'h11000);
    chk("status", 17'(status_r), 17'h00004);
    run(reduce_into_accumulator, 8'h10, 8'h00, 11'h000);
    chk("acc", 17'(acc_r), 17'h000FF);
    chk("mem_we", 17'(mem_wr_r.we), 17'h00000);
    chk("status", 17'(status_r), 17'h00000);
    run(reduce_in_place, 8'h10, 8'h00, 11'h000);
    chk("mem_wr", mem_wr_r, 17'h110FF);
    run(raise_into_accumulator, 8'h10, 8'h00, 11'h000);
    chk("acc", 17'(acc_r), 17'h00000);
    chk("status", 17'(status_r), 17'h00004);
    run(copy_operation_lit_to_acc, 8'h00, 8'h5A, 11'h000);
    run(copy_operation_mem_to_acc, 8'h10, 8'h00, 11'h000);
    chk("acc", 17'(acc_r), 17'h000FF);
    chk("status", 17'(status_r), 17'h00004);
    run(jump_unconditional, 8'h00, 8'h00, 11'h7A5);
    chk("pc", 17'(pc_r), 17'h007A5);
    chk("status", 17'(status_r), 17'h00004);
    run(copy_operation_lit_to_acc, 8'h00, 8'h01, 11'h000);
    chk("pc", 17'(pc_r), 17'h007A6);
    run(op_nop, 8'h00, 8'h00, 11'h000);
    chk("pc", 17'(pc_r), 17'h007A7);
    chk("acc", 17'(acc_r), 17'h00001);
    watchdog_timeout = 1'b1;
    @(posedge core_clk) #5;
    watchdog_timeout = 1'b0;
    run(power_down, 8'h00, 8'h00, 11'h000);
    chk("status", 17'(status_r), 17'h00006);
    chk("wd_clear", 17'(watchdog_clear_r), 17'h00001);
    repeat (10) @(posedge core_clk) #5;
    chk("clk_run", 17'(clk_run_r), 17'h00000);
    chk("acc", 17'(acc_r), 17'h00001);
    wake = 1'b1;
    repeat (6) @(posedge core_clk) #5;
    wake = 1'b0;
    chk("clk_run", 17'(clk_run_r), 17'h00001);
    run(copy_operation_mem_to_acc, 8'h10, 8'h00, 11'h000);
    chk("acc", 17'(acc_r), 17'h000FF);
    final_report();
  end

  initial
  begin
    #50000;
    error_cnt++;
    final_report();
  end
endmodule
